// [rtl/smi_pkg.sv]
// Purpose: shared constants and types of the sample memory interface
// Assumes: one clock, synchronous active-high reset
// Notes: all stage lengths are one clock cycle
//
// What this block does
// - static cycles hold full address throughout
// - dram row and column share low twelve lines
// - upper write strobe only for upper writes
// - lower write strobe only for lower writes
// - row address first, then row strobe
// - row strobe also low in static cycles
// - column strobes precede row strobe when static
// - selected column strobe follows column address
// - static chip select follows full address
// - three devices, device zero is rom
// - kind strap low static, high dram
// - size strap picks 64k to 4m dram
// - cpu and synthesizer slots strictly alternate
// - owner output low cpu, high synthesizer
package smi_pkg;

    // ------------------------------------------------------------
    // widths and codes
    // ------------------------------------------------------------
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    localparam int MUX_W = 12;
    localparam int NDEV = 3;
    localparam logic [1:0] DEV_ROM = 2'h0;
    localparam logic [1:0] DEV_NONE = 2'h3;
    localparam logic KIND_STATIC = 1'b0;
    localparam logic KIND_DRAM = 1'b1;
    localparam logic OWNER_CPU = 1'b0;
    localparam logic OWNER_SYN = 1'b1;
    localparam logic [1:0] SIZE_64K = 2'h0;
    localparam logic [1:0] SIZE_256K = 2'h1;
    localparam logic [1:0] SIZE_1M = 2'h2;
    localparam logic [1:0] SIZE_4M = 2'h3;
    // row and column width per dram size
    localparam logic [3:0] RC_BITS_64K = 4'h8;
    localparam logic [3:0] RC_BITS_256K = 4'h9;
    localparam logic [3:0] RC_BITS_1M = 4'ha;
    localparam logic [3:0] RC_BITS_4M = 4'hb;
    localparam logic [2:0] CAS_ALL_HIGH = 3'h7;
    localparam logic [2:0] CAS_REFRESH = 3'h6;
    localparam logic [2:0] CAS_ONE = 3'h1;
    localparam logic [1:0] WE_ALL_HIGH = 2'h3;
    localparam logic [10:0] UPPER_ZERO = 11'h000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] dev;
        logic [1:0] be;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } smi_req_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_ST_ADDR = 4'h1,
        S_ST_SEL = 4'h2,
        S_ST_RAS = 4'h3,
        S_ST_DATA = 4'h4,
        S_DR_ROW = 4'h5,
        S_DR_RAS = 4'h6,
        S_DR_COL = 4'h7,
        S_DR_CAS = 4'h8,
        S_DR_DATA = 4'h9,
        S_END = 4'ha
    } smi_state_t;

endpackage

// [rtl/smi_addr_mux.sv]
// Purpose: split a device word address into dram row and column
// Assumes: size code is stable while used
// Notes: purely combinational
`timescale 1ns/1ps
module smi_addr_mux
    import smi_pkg::*;
(
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [1:0] size_i,
    output logic [MUX_W-1:0] row_o,
    output logic [MUX_W-1:0] col_o
);

    // ------------------------------------------------------------
    // size decode
    // ------------------------------------------------------------
    wire [3:0] rc_bits;
    wire [ADDR_W-1:0] shifted;

    // width of row and column for the strapped size
    assign rc_bits = (size_i == SIZE_64K) ? RC_BITS_64K :
                     (size_i == SIZE_256K) ? RC_BITS_256K :
                     (size_i == SIZE_1M) ? RC_BITS_1M : RC_BITS_4M;
    assign shifted = addr_i >> rc_bits;

    // ------------------------------------------------------------
    // per-bit masking
    // ------------------------------------------------------------
    // unused upper lines read zero
    for (genvar i = 0; i < MUX_W; i++) begin : g_bit
        assign col_o[i] = (4'(i) < rc_bits) ? addr_i[i] : 1'b0;
        assign row_o[i] = (4'(i) < rc_bits) ? shifted[i] : 1'b0;
    end

endmodule

// [rtl/smi_core.sv]
// Purpose: sample memory interface shared by cpu and synthesizer
// Assumes: requesters hold their request until their done pulse
// Notes: one slot per access, owners alternate slot by slot
`timescale 1ns/1ps
module smi_core
    import smi_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire smi_req_t cpu_req_i,
    input wire smi_req_t syn_req_i,
    output logic cpu_done_o,
    output logic syn_done_o,
    output logic [DATA_W-1:0] rdata_o,
    input wire logic memory_kind_strap_i,
    input wire logic [1:0] dram_size_strap_i,
    output logic [ADDR_W-1:0] mem_addr_bus_o,
    output logic [DATA_W-1:0] mem_data_bus_o,
    output logic mem_data_bus_oe_o,
    input wire logic [DATA_W-1:0] mem_data_bus_i,
    output logic upper_byte_write_n_o,
    output logic lower_byte_write_n_o,
    output logic row_strobe_n_o,
    output logic [NDEV-1:0] col_strobe_n_o,
    output logic mem_owner_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    smi_state_t state_r, state_nxt;
    smi_req_t req_r;
    logic kind_r;
    logic [1:0] size_r;
    logic owner_r;

    // ------------------------------------------------------------
    // request selection
    // ------------------------------------------------------------
    wire smi_req_t new_req;
    wire smi_req_t cur_req;
    wire in_idle;
    wire kind_w;
    wire [1:0] size_w;
    wire cur_dram;
    wire cur_ext;
    wire cur_wr;
    wire [MUX_W-1:0] row_w;
    wire [MUX_W-1:0] col_w;

    // only the owner of this slot may start an access
    assign new_req = owner_r ? syn_req_i : cpu_req_i;
    assign in_idle = (state_r == S_IDLE);
    assign cur_req = in_idle ? new_req : req_r;
    assign kind_w = in_idle ? memory_kind_strap_i : kind_r;
    assign size_w = in_idle ? dram_size_strap_i : size_r;
    assign cur_ext = (cur_req.dev != DEV_NONE);
    // devices 1 and 2 follow the kind strap, device 0 is always rom
    assign cur_dram = cur_ext && (cur_req.dev != DEV_ROM)
                      && (kind_w == KIND_DRAM);
    // rom is never written
    assign cur_wr = cur_req.write && (cur_req.dev != DEV_ROM);

    smi_addr_mux u_mux (
        .addr_i (cur_req.addr),
        .size_i (size_w),
        .row_o (row_w),
        .col_o (col_w)
    );

    // ------------------------------------------------------------
    // slot sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = S_IDLE;
        case (state_r)
            S_IDLE: begin
                if (!new_req.valid) begin
                    state_nxt = S_IDLE;
                end else if (!cur_ext) begin
                    state_nxt = S_END;
                end else if (cur_dram) begin
                    state_nxt = S_DR_ROW;
                end else begin
                    state_nxt = S_ST_ADDR;
                end
            end
            S_ST_ADDR: state_nxt = S_ST_SEL;
            S_ST_SEL: state_nxt = S_ST_RAS;
            S_ST_RAS: state_nxt = S_ST_DATA;
            S_ST_DATA: state_nxt = S_END;
            S_DR_ROW: state_nxt = S_DR_RAS;
            S_DR_RAS: state_nxt = S_DR_COL;
            S_DR_COL: state_nxt = S_DR_CAS;
            S_DR_CAS: state_nxt = S_DR_DATA;
            S_DR_DATA: state_nxt = S_END;
            S_END: state_nxt = S_IDLE;
            default: state_nxt = S_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // next pin values, decoded from the next state
    // ------------------------------------------------------------
    wire nx_static;
    wire nx_row;
    wire nx_col;
    wire nx_ras;
    wire nx_cs;
    wire nx_we;
    wire nx_active;
    wire nx_data;
    wire [2:0] dev_sel;
    wire [2:0] refresh_sel;
    wire [ADDR_W-1:0] addr_nxt;
    wire [2:0] cas_n_nxt;
    wire [1:0] we_n_nxt;
    wire ras_n_nxt;
    wire owner_nxt;
    wire [DATA_W-1:0] rdata_nxt;

    assign nx_static = (state_nxt == S_ST_ADDR) || (state_nxt == S_ST_SEL)
                       || (state_nxt == S_ST_RAS) || (state_nxt == S_ST_DATA);
    assign nx_row = (state_nxt == S_DR_ROW) || (state_nxt == S_DR_RAS);
    assign nx_col = (state_nxt == S_DR_COL) || (state_nxt == S_DR_CAS)
                    || (state_nxt == S_DR_DATA);
    // row strobe after the row address, also in static cycles
    assign nx_ras = (state_nxt == S_DR_RAS) || nx_col
                    || (state_nxt == S_ST_RAS)
                    || (state_nxt == S_ST_DATA);
    assign nx_cs = (state_nxt == S_ST_SEL) || (state_nxt == S_ST_RAS)
                   || (state_nxt == S_ST_DATA) || (state_nxt == S_DR_CAS)
                   || (state_nxt == S_DR_DATA);
    assign nx_we = (state_nxt == S_ST_RAS) || (state_nxt == S_ST_DATA)
                   || (state_nxt == S_DR_CAS) || (state_nxt == S_DR_DATA);
    assign nx_active = nx_static || nx_row || nx_col;
    assign nx_data = (state_r == S_ST_DATA) || (state_r == S_DR_DATA);
    assign dev_sel = CAS_ONE << cur_req.dev;
    // dram on devices 1 and 2 gets cas-before-ras during static cycles
    assign refresh_sel = (nx_static && kind_w == KIND_DRAM)
                         ? CAS_REFRESH : 3'h0;
    // full address in static cycles, row then column for dram
    assign addr_nxt = nx_static ? cur_req.addr :
                      nx_row ? {UPPER_ZERO, row_w} :
                      nx_col ? {UPPER_ZERO, col_w} :
                      mem_addr_bus_o;
    assign cas_n_nxt = nx_cs ? ~(dev_sel | refresh_sel)
                             : CAS_ALL_HIGH;
    assign ras_n_nxt = ~nx_ras;
    // each byte strobe only for its own lane on a real write
    assign we_n_nxt = (nx_we && cur_wr) ? ~cur_req.be
                                        : WE_ALL_HIGH;
    // the slot passes on after each access or an empty slot
    assign owner_nxt = ((state_r == S_END) || (in_idle && !new_req.valid))
                       ? ~owner_r : owner_r;
    assign rdata_nxt = nx_data ? mem_data_bus_i : rdata_o;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // sequencer and captured request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= S_IDLE;
            req_r <= '0;
            kind_r <= KIND_STATIC;
            size_r <= SIZE_64K;
            owner_r <= OWNER_CPU;
        end else begin
            state_r <= state_nxt;
            owner_r <= owner_nxt;
            if (in_idle) begin
                req_r <= new_req;
                kind_r <= memory_kind_strap_i;
                size_r <= dram_size_strap_i;
            end
        end
    end

    // registered pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_addr_bus_o <= '0;
            mem_data_bus_o <= '0;
            mem_data_bus_oe_o <= 1'b0;
            row_strobe_n_o <= 1'b1;
            col_strobe_n_o <= CAS_ALL_HIGH;
            upper_byte_write_n_o <= 1'b1;
            lower_byte_write_n_o <= 1'b1;
            mem_owner_o <= OWNER_CPU;
            cpu_done_o <= 1'b0;
            syn_done_o <= 1'b0;
            rdata_o <= '0;
        end else begin
            mem_addr_bus_o <= addr_nxt;
            mem_data_bus_o <= cur_req.wdata;
            mem_data_bus_oe_o <= nx_active && cur_wr;
            row_strobe_n_o <= ras_n_nxt;
            col_strobe_n_o <= cas_n_nxt;
            upper_byte_write_n_o <= we_n_nxt[1];
            lower_byte_write_n_o <= we_n_nxt[0];
            mem_owner_o <= owner_nxt;
            cpu_done_o <= (state_nxt == S_END) && (state_r != S_END)
                          && (owner_r == OWNER_CPU);
            syn_done_o <= (state_nxt == S_END) && (state_r != S_END)
                          && (owner_r == OWNER_SYN);
            rdata_o <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    wire st_hold = (state_r == S_ST_SEL) || (state_r == S_ST_RAS)
                   || (state_r == S_ST_DATA);

    property p_static_addr_hold;
        @(posedge clk_i) disable iff (rst_i)
        st_hold |-> $stable(mem_addr_bus_o);
    endproperty
    a_static_addr_hold: assert property (p_static_addr_hold)
        else $error("address moved during static cycle");

    property p_dram_low_lines;
        @(posedge clk_i) disable iff (rst_i)
        (state_r == S_DR_RAS) |-> mem_addr_bus_o[ADDR_W-1:MUX_W] == UPPER_ZERO
            ##2 mem_addr_bus_o[ADDR_W-1:MUX_W] == UPPER_ZERO;
    endproperty
    a_dram_low_lines: assert property (p_dram_low_lines)
        else $error("dram address outside low lines");

    property p_upper_we;
        @(posedge clk_i) disable iff (rst_i)
        !upper_byte_write_n_o |-> req_r.write && req_r.be[1]
            && req_r.dev != DEV_ROM && mem_data_bus_oe_o;
    endproperty
    a_upper_we: assert property (p_upper_we)
        else $error("upper write strobe without upper write");

    property p_lower_we;
        @(posedge clk_i) disable iff (rst_i)
        !lower_byte_write_n_o |-> req_r.write && req_r.be[0]
            && req_r.dev != DEV_ROM && mem_data_bus_oe_o;
    endproperty
    a_lower_we: assert property (p_lower_we)
        else $error("lower write strobe without lower write");

    property p_row_before_ras;
        @(posedge clk_i) disable iff (rst_i)
        (state_r == S_DR_ROW) |=> $fell(row_strobe_n_o)
            && $stable(mem_addr_bus_o);
    endproperty
    a_row_before_ras: assert property (p_row_before_ras)
        else $error("row strobe not after row address");

    property p_static_ras;
        @(posedge clk_i) disable iff (rst_i)
        (state_r == S_ST_SEL) |=> !row_strobe_n_o [*2] ##1 row_strobe_n_o;
    endproperty
    a_static_ras: assert property (p_static_ras)
        else $error("no row strobe in static cycle");

    property p_cbr_order;
        @(posedge clk_i) disable iff (rst_i)
        (state_r == S_ST_SEL && kind_r == KIND_DRAM) |->
            col_strobe_n_o[2:1] == 2'h0 && row_strobe_n_o;
    endproperty
    a_cbr_order: assert property (p_cbr_order)
        else $error("refresh column strobes not ahead of row strobe");

    property p_dram_cas;
        @(posedge clk_i) disable iff (rst_i)
        (state_r == S_DR_CAS) |-> col_strobe_n_o == ~(CAS_ONE << req_r.dev)
            && $stable(mem_addr_bus_o) && $past(state_r) == S_DR_COL;
    endproperty
    a_dram_cas: assert property (p_dram_cas)
        else $error("wrong dram column strobe");

    property p_static_cs;
        @(posedge clk_i) disable iff (rst_i)
        (state_r == S_ST_ADDR) |-> col_strobe_n_o == CAS_ALL_HIGH
            ##1 !col_strobe_n_o[req_r.dev];
    endproperty
    a_static_cs: assert property (p_static_cs)
        else $error("chip select not after address");

    property p_rom_readonly;
        @(posedge clk_i) disable iff (rst_i)
        (state_r != S_IDLE && req_r.dev == DEV_ROM) |->
            upper_byte_write_n_o && lower_byte_write_n_o;
    endproperty
    a_rom_readonly: assert property (p_rom_readonly)
        else $error("write strobe on rom");

    property p_kind_strap;
        @(posedge clk_i) disable iff (rst_i)
        (state_r == S_ST_ADDR && req_r.dev != DEV_ROM) |->
            kind_r == KIND_STATIC;
    endproperty
    a_kind_strap: assert property (p_kind_strap)
        else $error("static cycle on dram device");

    property p_owner_toggle;
        @(posedge clk_i) disable iff (rst_i)
        (state_r == S_END) |=> mem_owner_o != $past(mem_owner_o)
            ##1 ($stable(mem_owner_o) || !$past(new_req.valid));
    endproperty
    a_owner_toggle: assert property (p_owner_toggle)
        else $error("owner did not alternate");

    property p_owner_level;
        @(posedge clk_i) disable iff (rst_i)
        (cpu_done_o |-> mem_owner_o == OWNER_CPU)
        and (syn_done_o |-> mem_owner_o == OWNER_SYN);
    endproperty
    a_owner_level: assert property (p_owner_level)
        else $error("done given outside owner slot");

    property p_idle_quiet;
        @(posedge clk_i) disable iff (rst_i)
        (state_r == S_IDLE || state_r == S_END) |-> row_strobe_n_o
            && col_strobe_n_o == CAS_ALL_HIGH
            && upper_byte_write_n_o && lower_byte_write_n_o;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("strobe active between accesses");

    property p_cov_static_read;
        @(posedge clk_i) disable iff (rst_i)
        (state_r == S_ST_DATA && !req_r.write) ##1 cpu_done_o;
    endproperty
    c_static_read: cover property (p_cov_static_read);

    property p_cov_dram_write;
        @(posedge clk_i) disable iff (rst_i)
        state_r == S_DR_CAS && !upper_byte_write_n_o;
    endproperty
    c_dram_write: cover property (p_cov_dram_write);

    property p_cov_refresh;
        @(posedge clk_i) disable iff (rst_i)
        state_r == S_ST_SEL && kind_r == KIND_DRAM;
    endproperty
    c_refresh: cover property (p_cov_refresh);

    property p_cov_syn_access;
        @(posedge clk_i) disable iff (rst_i)
        syn_done_o;
    endproperty
    c_syn_access: cover property (p_cov_syn_access);

endmodule

// [dv/smi_mem_model.sv]
// Purpose: rom, sram and dram devices on the sample memory bus
// Assumes: strobes and address come straight from the core
// Notes: undriven cycles show the inverse of the model's own last output
`timescale 1ns/1ps
module smi_mem_model
    import smi_pkg::*;
#(
    parameter logic [15:0] ROM_KEY = 16'h5a5a
)
(
    input wire logic clk_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic oe_i,
    input wire logic upper_we_n_i,
    input wire logic lower_we_n_i,
    input wire logic row_strobe_n_i,
    input wire logic [NDEV-1:0] col_strobe_n_i,
    input wire logic kind_i,
    output logic [DATA_W-1:0] rdata_o
);
    logic [15:0] mem [int];
    logic [11:0] row_r = 12'h000;
    logic refr_r = 1'b0;
    logic row_p_r = 1'b1;
    logic [15:0] last_r = 16'h0000;
    logic [15:0] val;
    logic [15:0] tmp;
    logic [1:0] d;
    logic hit;
    logic stat;
    int key;

    // pick the selected device and the cell it addresses
    always @* begin
        hit = 1'b0;
        d = 2'h0;
        stat = 1'b1;
        for (int i = 0; i < 3; i++) begin
            if (!col_strobe_n_i[i] && (i == 0 || !kind_i ||
                (!row_strobe_n_i && !refr_r))) begin
                hit = 1'b1;
                d = 2'(i);
                stat = (i == 0) || !kind_i;
            end
        end
        key = stat ? int'({d, addr_i})
            : int'({1'b1, d, row_r, addr_i[11:0]});
        if (d == 2'h0) begin
            val = addr_i[15:0] ^ ROM_KEY;
        end else begin
            val = mem.exists(key) ? mem[key] : 16'h0000;
        end
        rdata_o = (hit && !oe_i) ? val : ~last_r;
    end

    // row latch, refresh detection and byte writes
    always @(posedge clk_i) begin
        if (row_p_r && !row_strobe_n_i && &col_strobe_n_i) begin
            row_r <= addr_i[11:0];
        end
        if (row_strobe_n_i && !(&col_strobe_n_i)) begin
            refr_r <= 1'b1;
        end else if (&col_strobe_n_i) begin
            refr_r <= 1'b0;
        end
        row_p_r <= row_strobe_n_i;
        last_r <= rdata_o;
        tmp = mem.exists(key) ? mem[key] : 16'h0000;
        if (!upper_we_n_i) tmp[15:8] = wdata_i[15:8];
        if (!lower_we_n_i) tmp[7:0] = wdata_i[7:0];
        if (hit && d != 2'h0 && !(upper_we_n_i && lower_we_n_i)) begin
            mem[key] = tmp;
        end
    end
endmodule

// [dv/sample_memory_interface_bench.sv]
// Purpose: self-checking bench of the sample memory interface
// Assumes: inputs change at the falling clock edge
// Notes: a monitor judges strobes and address every cycle
`timescale 1ns/1ps
module sample_memory_interface_bench;
    import smi_pkg::*;

    logic clk_i;
    logic rst_i;
    smi_req_t cpu_req;
    smi_req_t syn_req;
    logic cpu_done_o;
    logic syn_done_o;
    logic [DATA_W-1:0] rdata_o;
    logic kind;
    logic [1:0] size;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] din;
    logic [DATA_W-1:0] mdl;
    logic oe;
    logic we1_n;
    logic we0_n;
    logic ras_n;
    logic [NDEV-1:0] cas_n;
    logic mem_owner_o;
    logic busy;
    int errors = 0;
    int num_checks = 0;
    smi_req_t mr;
    logic dr;
    logic ras_p = 1'b1;
    logic [2:0] cas_p = 3'h7;

    // --------------------------------------------------------------
    // design, memory devices and the shared data bus
    // --------------------------------------------------------------
    smi_core i_smi_core (
        .clk_i(clk_i), .rst_i(rst_i),
        .cpu_req_i(cpu_req), .syn_req_i(syn_req),
        .cpu_done_o(cpu_done_o), .syn_done_o(syn_done_o),
        .rdata_o(rdata_o), .memory_kind_strap_i(kind),
        .dram_size_strap_i(size), .mem_addr_bus_o(addr),
        .mem_data_bus_o(dout), .mem_data_bus_oe_o(oe),
        .mem_data_bus_i(din), .upper_byte_write_n_o(we1_n),
        .lower_byte_write_n_o(we0_n), .row_strobe_n_o(ras_n),
        .col_strobe_n_o(cas_n), .mem_owner_o(mem_owner_o)
    );
    smi_mem_model i_smi_mem_model (
        .clk_i(clk_i), .addr_i(addr), .wdata_i(dout), .oe_i(oe),
        .upper_we_n_i(we1_n), .lower_we_n_i(we0_n),
        .row_strobe_n_i(ras_n), .col_strobe_n_i(cas_n),
        .kind_i(kind), .rdata_o(mdl)
    );
    assign din = oe ? dout : mdl; // core drives while writing

    // clock source
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic chk(input logic [22:0] s, input logic [22:0] e);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("BAD t=%0t seen %h want %h", $time, s, e);
        end
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    function automatic smi_req_t rq(logic w, logic [1:0] dv,
        logic [1:0] be, logic [22:0] a, logic [15:0] wd);
        return {1'b1, w, dv, be, a, wd};
    endfunction

    function automatic logic [15:0] rom(logic [22:0] a);
        return a[15:0] ^ 16'h5a5a;
    endfunction

    // dram row or column half of an address for the strapped size
    function automatic logic [11:0] rc(logic [22:0] a, logic row);
        int n;
        n = 8 + int'(size);
        return 12'((row ? a >> n : a) & ((23'h1 << n) - 23'h1));
    endfunction

    // one access by one requester, held until its done pulse
    task automatic go(input logic syn, input smi_req_t r,
        input logic [15:0] exp);
        int n;
        @(negedge clk_i);
        busy = 1'b1;
        if (syn) syn_req = r;
        else cpu_req = r;
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while ((syn ? syn_done_o : cpu_done_o) !== 1'b1 && n < 60);
        chk(23'(n < 60), 23'h1);
        chk(23'(mem_owner_o), 23'(syn));
        if (!r.write) chk(23'(rdata_o), 23'(exp));
        @(negedge clk_i);
        cpu_req = '0;
        syn_req = '0;
        busy = 1'b0;
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_rom;
        go(1'b0, rq(1'b0, DEV_ROM, 2'h3, 23'h7fffff, 16'h0),
            rom(23'h7fffff));
        go(1'b1, rq(1'b0, DEV_ROM, 2'h3, 23'h000001, 16'h0),
            rom(23'h000001));
        go(1'b1, rq(1'b1, DEV_ROM, 2'h3, 23'h000001, 16'hffff), 16'h0);
        go(1'b0, rq(1'b0, DEV_ROM, 2'h3, 23'h000001, 16'h0),
            rom(23'h000001));
        go(1'b0, rq(1'b0, DEV_NONE, 2'h3, 23'h000005, 16'h0),
            rom(23'h000001));
        $display("test rom done");
    endtask

    task automatic t_sram;
        kind = KIND_STATIC;
        @(negedge clk_i);
        go(1'b1, rq(1'b1, 2'h1, 2'h3, 23'h45678, 16'hbeef), 16'h0);
        go(1'b0, rq(1'b1, 2'h1, 2'h1, 23'h45678, 16'h1234), 16'h0);
        go(1'b1, rq(1'b1, 2'h1, 2'h2, 23'h45678, 16'h56aa), 16'h0);
        go(1'b0, rq(1'b1, 2'h2, 2'h3, 23'h45678, 16'h0f0f), 16'h0);
        go(1'b1, rq(1'b0, 2'h1, 2'h3, 23'h45678, 16'h0), 16'h5634);
        go(1'b0, rq(1'b0, 2'h2, 2'h3, 23'h45678, 16'h0), 16'h0f0f);
        $display("test sram done");
    endtask

    task automatic t_dram;
        logic [22:0] a;
        kind = KIND_DRAM;
        for (int s = 0; s < 4; s++) begin
            size = 2'(s);
            @(negedge clk_i);
            a = (23'h1 << (15 + 2 * s)) | (23'h2 << (8 + s)) | 23'h3;
            go(1'b1, rq(1'b1, 2'h2, 2'h3, a, 16'h1230 + 16'(s)), 16'h0);
            go(1'b0, rq(1'b0, 2'h2, 2'h3, a, 16'h0), 16'h1230 + 16'(s));
        end
        go(1'b0, rq(1'b0, DEV_ROM, 2'h3, 23'h3abcd, 16'h0),
            rom(23'h3abcd));
        kind = KIND_STATIC;
        @(negedge clk_i);
        $display("test dram done");
    endtask

    // both requesters keep asking; dones must alternate owners
    task automatic t_alt;
        int n;
        int k;
        logic who;
        logic prev;
        busy = 1'b1;
        cpu_req = rq(1'b0, DEV_ROM, 2'h3, 23'h10, 16'h0);
        syn_req = rq(1'b0, DEV_ROM, 2'h3, 23'h20, 16'h0);
        k = 0;
        n = 0;
        prev = 1'b0;
        while (k < 4 && n < 100) begin
            @(posedge clk_i);
            #1;
            n++;
            if (cpu_done_o === 1'b1 || syn_done_o === 1'b1) begin
                who = syn_done_o;
                chk(23'(mem_owner_o), 23'(who));
                if (k > 0) chk(23'(who), 23'(!prev));
                chk(23'(rdata_o), 23'(rom(who ? 23'h20 : 23'h10)));
                prev = who;
                k++;
            end
        end
        chk(23'(k), 23'h4);
        @(negedge clk_i);
        cpu_req = '0;
        syn_req = '0;
        busy = 1'b0;
        $display("test alternation done");
    endtask

    // judge strobes and address against the owner's request
    always @(posedge clk_i) begin
        #1;
        mr = mem_owner_o ? syn_req : cpu_req;
        dr = kind && mr.dev != DEV_ROM;
        if (!rst_i && mr.dev != DEV_NONE) begin
            if (we1_n === 1'b0) chk(23'(mr.write & mr.be[1]
                & (mr.dev != DEV_ROM)), 23'h1);
            if (we0_n === 1'b0) chk(23'(mr.write & mr.be[0]
                & (mr.dev != DEV_ROM)), 23'h1);
            if (!dr && cas_n[mr.dev] === 1'b0) chk(addr, mr.addr);
            if (ras_p && ras_n === 1'b0) begin
                if (dr) chk(23'(addr[11:0]), 23'(rc(mr.addr, 1)));
                else chk(23'(cas_n), 23'(kind ? 3'h0
                    : 3'(~(3'h1 << mr.dev))));
            end
            if (dr && cas_p[mr.dev] && cas_n[mr.dev] === 1'b0) begin
                chk(23'(addr[11:0]), 23'(rc(mr.addr, 0)));
            end
        end
        if (!rst_i && (!busy || mr.dev == DEV_NONE))
            chk(23'({ras_n, cas_n, we1_n, we0_n}),
            23'h3f);
        ras_p = ras_n;
        cas_p = cas_n;
    end

    // watchdog cuts a hang short
    initial begin
        #200000;
        errors++;
        test_done;
    end

    // main sequence
    initial begin
        rst_i = 1'b1;
        cpu_req = '0;
        syn_req = '0;
        kind = KIND_STATIC;
        size = SIZE_64K;
        busy = 1'b0;
        repeat (12) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        @(negedge clk_i);
        t_rom;
        t_sram;
        t_dram;
        t_alt;
        test_done;
    end
endmodule
